// File: core/uch_pkg.sv
// Constants and types for one UART channel register set
//
// Behaviour
// RL1: each channel owns its own register set
// RL2: addr 0 reads rx holding, writes tx
// RL3: divisor access maps divisors and alternate function
// RL4: addr 1 is interrupt enable, read/write
// RL5: addr 2 reads status, writes FIFO control
// RL6: line and modem control always accessible
// RL7: addr 5/6 read status, writes ignored
// RL8: addr 7 is a scratch byte
// RL9: four enable bits, upper nibble reads zero
// RL10: status code low, FIFO enabled high bits
// RL11: sixteen-bit divisor from two bytes
// RL12: receive interrupt follows fill versus trigger
// RL13: receive code and interrupt clear together
// RL14: data ready set on push, clear empty
// RL15: status bit zero high when nothing pending
// RL16: without enable bit a FIFO control write only clears the enable
// RL17: trigger select gives 1, 4, 8, 14
// RL18: source codes in fixed priority order
// RL19: FIFO control field layout
// RL20: alternate function field layout
package uch_pkg;

  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IEN = 3'h1;
  localparam logic [2:0] ADDR_ISTAT = 3'h2;
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_MCTL = 3'h4;
  localparam logic [2:0] ADDR_LSTAT = 3'h5;
  localparam logic [2:0] ADDR_MSTAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  localparam int LCTL_DIV_BIT = 7;
  localparam int FCTL_EN_BIT = 0;
  localparam int FCTL_RXRST_BIT = 1;
  localparam int FCTL_TXRST_BIT = 2;
  localparam int FCTL_DMA_BIT = 3;
  localparam int FCTL_TRIG_LSB = 6;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [3:0] IEN_MASK = 4'hF;
  localparam logic [2:0] ALT_MASK = 3'h7;
  localparam logic [7:0] LSTAT_RESET = 8'h60;

  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;

  localparam logic [3:0] SRC_LINE = 4'h6;
  localparam logic [3:0] SRC_TIMEOUT = 4'hC;
  localparam logic [3:0] SRC_RXDATA = 4'h4;
  localparam logic [3:0] SRC_TXRDY = 4'h2;
  localparam logic [3:0] SRC_MODEM = 4'h0;
  localparam logic [3:0] SRC_NONE = 4'h1;

  typedef struct packed {
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } uch_req_s;

  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
    logic [7:0] data;
  } uch_rx_word_s;

  typedef struct packed {
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [15:0] divisor;
    logic [2:0] alt_func;
    logic fifo_en;
    logic dma_mode;
  } uch_cfg_s;

endpackage

// File: core/uch_regs.sv
// Register set, FIFOs and interrupt status of one UART channel
`timescale 1ns/1ps
module uch_regs import uch_pkg::*; #(
  parameter logic CHANNEL_ID = 1'b0,
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host bus, one-cycle rd/wr strobes
  input wire logic cs_n,
  input wire logic channel_pick,
  input wire uch_req_s req,
  output logic [7:0] rdata,
  // From receive shift register
  input wire logic rx_valid,
  output logic rx_ready,
  input wire uch_rx_word_s rx_word,
  input wire logic rx_overrun,
  input wire logic rx_timeout,
  // To transmit shift register
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  input wire logic tx_shift_idle,
  // Modem inputs, active-high levels and change pulses
  input wire logic [3:0] modem_level,
  input wire logic [3:0] modem_delta,
  // Configuration and interrupt
  output uch_cfg_s cfg,
  output logic irq
);

  localparam int RW = $clog2(RX_DEPTH);
  localparam int TW = $clog2(TX_DEPTH);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);

  if (RX_DEPTH < 16 || TX_DEPTH < 2 ||
      (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
      (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_check
    $error("uch_regs: depths must be powers of two, rx at least 16");
  end

  //////////////////////////////////////////////////////////////////////
  // Decode

  logic sel, rd, wr, dl, fifo_en, dma_mode;
  logic [7:0] line_ctl, modem_ctl, div_lo, div_hi, scratch;
  logic [2:0] alt_func;
  logic [3:0] int_en;
  logic [1:0] trig_sel;

  // Concurrent write lets one host write reach both channels
  assign sel = !cs_n && (channel_pick == CHANNEL_ID); // RL1
  assign rd = sel && req.rd;
  assign wr = (sel || (!cs_n && alt_func[0])) && req.wr; // RL20
  assign dl = line_ctl[LCTL_DIV_BIT];

  logic wr_tx_hold, wr_fifo_ctl, rd_rx_hold, rd_int_stat;
  logic rd_line_stat, rd_modem_stat;

  assign wr_tx_hold = wr && !dl && req.addr == ADDR_DATA; // RL2
  assign wr_fifo_ctl = wr && !dl && req.addr == ADDR_ISTAT; // RL5
  assign rd_rx_hold = rd && !dl && req.addr == ADDR_DATA; // RL2
  assign rd_int_stat = rd && !dl && req.addr == ADDR_ISTAT; // RL5
  assign rd_line_stat = rd && req.addr == ADDR_LSTAT; // RL7
  assign rd_modem_stat = rd && req.addr == ADDR_MSTAT; // RL7

  //////////////////////////////////////////////////////////////////////
  // Plain read/write registers

  always_ff @(posedge clk) begin
    if (reset) begin
      line_ctl <= REG_RESET;
      modem_ctl <= REG_RESET;
      scratch <= REG_RESET;
    end else if (wr) begin
      unique case (req.addr)
        ADDR_LCTL: line_ctl <= req.wdata; // RL6
        ADDR_MCTL: modem_ctl <= req.wdata; // RL6
        ADDR_SCRATCH: scratch <= req.wdata; // RL8
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_lo <= DIV_RESET;
      div_hi <= DIV_RESET;
      alt_func <= '0;
      int_en <= '0;
    end else if (wr && dl) begin
      unique case (req.addr)
        ADDR_DATA: div_lo <= req.wdata; // RL3
        ADDR_IEN: div_hi <= req.wdata; // RL3 RL11
        ADDR_ISTAT: alt_func <= req.wdata[2:0] & ALT_MASK; // RL20
        default: ;
      endcase
    end else if (wr && req.addr == ADDR_IEN) begin
      int_en <= req.wdata[3:0] & IEN_MASK; // RL4 RL9
    end
  end

  // FIFO control; without the enable bit only the disable takes
  logic rx_flush, tx_flush;

  always_ff @(posedge clk) begin
    if (reset) begin
      fifo_en <= 1'b0;
      dma_mode <= 1'b0;
      trig_sel <= 2'h0;
    end else if (wr_fifo_ctl) begin
      fifo_en <= req.wdata[FCTL_EN_BIT]; // RL16
      if (req.wdata[FCTL_EN_BIT]) begin
        dma_mode <= req.wdata[FCTL_DMA_BIT]; // RL19
        trig_sel <= req.wdata[FCTL_TRIG_LSB +: 2]; // RL17
      end
    end
  end

  // Reset bits self-clear: they act as a pulse only
  assign rx_flush = wr_fifo_ctl && req.wdata[FCTL_EN_BIT] &&
                    req.wdata[FCTL_RXRST_BIT]; // RL16 RL19
  assign tx_flush = wr_fifo_ctl && req.wdata[FCTL_EN_BIT] &&
                    req.wdata[FCTL_TXRST_BIT]; // RL16 RL19

  assign cfg.line_ctl = line_ctl;
  assign cfg.modem_ctl = modem_ctl;
  assign cfg.divisor = {div_hi, div_lo}; // RL11
  assign cfg.alt_func = alt_func;
  assign cfg.fifo_en = fifo_en;
  assign cfg.dma_mode = dma_mode;

  //////////////////////////////////////////////////////////////////////
  // Receive FIFO

  uch_rx_word_s rx_mem [RX_DEPTH];
  logic [RW-1:0] rx_wp, rx_rp;
  logic [RCW-1:0] rx_cnt, rx_err_cnt, rx_limit;
  logic rx_push, rx_pop;
  uch_rx_word_s rx_head;

  // Without FIFO mode the holding register is a single entry
  assign rx_limit = fifo_en ? RCW'(RX_DEPTH) : RCW'(1);
  assign rx_ready = rx_cnt < rx_limit;
  assign rx_push = rx_valid && rx_ready;
  assign rx_pop = rd_rx_hold && rx_cnt != '0;
  assign rx_head = rx_mem[rx_rp];

  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_word;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || rx_flush) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wp <= rx_wp + RW'(rx_push);
      rx_rp <= rx_rp + RW'(rx_pop);
      rx_cnt <= rx_cnt + RCW'(rx_push) - RCW'(rx_pop);
    end
  end

  // Counts entries with error tags so the global flag needs no scan
  logic push_err;
  logic pop_err;

  assign push_err = rx_push && (rx_word.brk || rx_word.frame ||
                                rx_word.parity);
  assign pop_err = rx_pop && (rx_head.brk || rx_head.frame ||
                              rx_head.parity);

  always_ff @(posedge clk) begin
    if (reset || rx_flush) begin
      rx_err_cnt <= '0;
    end else begin
      rx_err_cnt <= rx_err_cnt + RCW'(push_err) - RCW'(pop_err);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transmit FIFO and two-entry output buffer

  logic [7:0] tx_mem [TX_DEPTH];
  logic [TW-1:0] tx_wp, tx_rp;
  logic [TCW-1:0] tx_cnt, tx_limit;
  logic tx_push, tx_move, owp, orp, tx_pop;
  logic [7:0] obuf [2];
  logic [1:0] ocnt;

  // Writes to a full holding path are dropped, as the host must poll
  assign tx_limit = fifo_en ? TCW'(TX_DEPTH) : TCW'(1);
  assign tx_push = wr_tx_hold && tx_cnt < tx_limit; // RL2
  assign tx_move = tx_cnt != '0 && ocnt != 2'h2;
  assign tx_valid = ocnt != 2'h0;
  assign tx_pop = tx_valid && tx_ready;
  assign tx_data = obuf[orp];

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || tx_flush) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wp <= tx_wp + TW'(tx_push);
      tx_rp <= tx_rp + TW'(tx_move);
      tx_cnt <= tx_cnt + TCW'(tx_push) - TCW'(tx_move);
    end
  end

  // The buffer keeps a stalled word so the receiver never loses one
  always_ff @(posedge clk) begin
    if (tx_move) begin
      obuf[owp] <= tx_mem[tx_rp];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      owp <= 1'b0;
      orp <= 1'b0;
      ocnt <= 2'h0;
    end else begin
      owp <= owp ^ tx_move;
      orp <= orp ^ tx_pop;
      ocnt <= ocnt + 2'(tx_move) - 2'(tx_pop);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky status flags, set wins over clear

  logic overrun, tx_was_empty, tx_empty, tx_int_flag;
  logic [3:0] mdelta, src;

  assign tx_empty = tx_cnt == '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      overrun <= 1'b0;
    end else if (rx_overrun) begin
      overrun <= 1'b1;
    end else if (rd_line_stat) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mdelta <= '0;
    end else begin
      mdelta <= modem_delta | (mdelta & {4{!rd_modem_stat}});
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_was_empty <= 1'b1;
      tx_int_flag <= 1'b0;
    end else begin
      tx_was_empty <= tx_empty;
      if (tx_empty && !tx_was_empty) begin
        tx_int_flag <= 1'b1;
      end else if (wr_tx_hold || (rd_int_stat && src == SRC_TXRDY)) begin
        tx_int_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt priority

  logic [RCW-1:0] trig_level;
  logic line_err;
  logic rx_data_int;

  always_comb begin
    unique case (trig_sel)
      2'h0: trig_level = RCW'(TRIG_1); // RL17
      2'h1: trig_level = RCW'(TRIG_4); // RL17
      2'h2: trig_level = RCW'(TRIG_8); // RL17
      2'h3: trig_level = RCW'(TRIG_14); // RL17
    endcase
  end

  // Error tags show for the head entry until it is read out
  assign line_err = overrun || (rx_cnt != '0 &&
                    (rx_head.brk || rx_head.frame || rx_head.parity));
  // Level compare: drops as soon as the fill falls below trigger
  assign rx_data_int = fifo_en ? rx_cnt >= trig_level
                               : rx_cnt != '0; // RL12 RL13

  always_comb begin
    if (int_en[2] && line_err) begin
      src = SRC_LINE; // RL18
    end else if (int_en[0] && fifo_en && rx_timeout &&
                 rx_cnt != '0) begin
      src = SRC_TIMEOUT; // RL18
    end else if (int_en[0] && rx_data_int) begin
      src = SRC_RXDATA; // RL12 RL13 RL18
    end else if (int_en[1] && tx_int_flag) begin
      src = SRC_TXRDY; // RL18
    end else if (int_en[3] && mdelta != '0) begin
      src = SRC_MODEM; // RL18
    end else begin
      src = SRC_NONE; // RL15
    end
  end

  assign irq = !src[0]; // RL13 RL15

  //////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] lstat, istat, next_rdata;

  assign lstat = {rx_err_cnt != '0,
                  tx_empty && ocnt == 2'h0 && tx_shift_idle,
                  tx_empty,
                  rx_cnt != '0 && rx_head.brk,
                  rx_cnt != '0 && rx_head.frame,
                  rx_cnt != '0 && rx_head.parity,
                  overrun,
                  rx_cnt != '0}; // RL14
  assign istat = {fifo_en, fifo_en, 2'h0, src}; // RL10

  always_comb begin
    next_rdata = REG_RESET;
    unique case (req.addr)
      ADDR_DATA: next_rdata = dl ? div_lo : rx_head.data; // RL2 RL3
      ADDR_IEN: next_rdata = dl ? div_hi : {4'h0, int_en}; // RL4 RL9
      ADDR_ISTAT: next_rdata = dl ? {5'h00, alt_func} : istat; // RL3 RL5
      ADDR_LCTL: next_rdata = line_ctl; // RL6
      ADDR_MCTL: next_rdata = modem_ctl; // RL6
      ADDR_LSTAT: next_rdata = lstat; // RL7
      ADDR_MSTAT: next_rdata = {modem_level, mdelta}; // RL7
      ADDR_SCRATCH: next_rdata = scratch; // RL8
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= REG_RESET;
    end else if (rd) begin
      rdata <= next_rdata;
    end
  end

endmodule

// File: tb/uch_assertions.sv
// Port checker for the UART channel register set
`timescale 1ns/1ps
module uch_assertions import uch_pkg::*; #(
  parameter logic CHANNEL_ID = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host bus
  input wire logic cs_n,
  input wire logic channel_pick,
  input wire uch_req_s req,
  // Streams, config and interrupt
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic rx_ready,
  input wire uch_cfg_s cfg,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic wr_ok;
  logic dv;
  // Concurrent write lets the other channel's select through
  assign wr_ok = req.wr && !cs_n &&
    (channel_pick == CHANNEL_ID || cfg.alt_func[0]);
  assign dv = cfg.line_ctl[LCTL_DIV_BIT];
  a_div_low: assert property (
    wr_ok && req.addr == ADDR_DATA && dv
    |=> cfg.divisor[7:0] == $past(req.wdata)) else $error("div low");
  a_div_high: assert property (
    wr_ok && req.addr == ADDR_IEN && dv
    |=> cfg.divisor[15:8] == $past(req.wdata)) else $error("div high");
  a_data_bank: assert property (
    wr_ok && req.addr == ADDR_DATA && !dv
    |=> $stable(cfg.divisor)) else $error("divisor hit");
  a_line_ctl: assert property (
    wr_ok && req.addr == ADDR_LCTL
    |=> cfg.line_ctl == $past(req.wdata)) else $error("line ctl");
  a_modem_ctl: assert property (
    wr_ok && req.addr == ADDR_MCTL
    |=> cfg.modem_ctl[4:0] == $past(req.wdata[4:0]))
    else $error("modem ctl");
  a_fifo_off: assert property (
    wr_ok && req.addr == ADDR_ISTAT && !dv && !req.wdata[FCTL_EN_BIT]
    |=> !cfg.fifo_en) else $error("fifo still on");
  a_fifo_on: assert property (
    wr_ok && req.addr == ADDR_ISTAT && !dv && req.wdata[FCTL_EN_BIT]
    |=> cfg.fifo_en && cfg.dma_mode == $past(req.wdata[FCTL_DMA_BIT]))
    else $error("fifo control");
  a_alt_func: assert property (
    wr_ok && req.addr == ADDR_ISTAT && dv
    |=> cfg.alt_func == $past(req.wdata[2:0])) else $error("alt func");
  a_reset_state: assert property (
    $fell(reset) |-> !irq && rx_ready && !tx_valid)
    else $error("reset state");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  c_divisor: cover property (wr_ok && dv && req.addr == ADDR_DATA);
  c_irq: cover property ($rose(irq));
  c_tx_stall: cover property (tx_valid && !tx_ready);
endmodule
bind uch_regs uch_assertions #(.CHANNEL_ID(CHANNEL_ID)) u_chk (
  .clk(clk), .reset(reset), .cs_n(cs_n), .channel_pick(channel_pick),
  .req(req), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .rx_ready(rx_ready), .cfg(cfg), .irq(irq));

// File: tb/uch_line_model.sv
// Transmit shifter stand-in that takes bytes with a settable stall
`timescale 1ns/1ps
module uch_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Byte stream from the channel
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic tx_shift_idle,
  // Stall length and what was taken
  input wire logic [2:0] slow,
  output logic got,
  output logic [7:0] got_byte
);
  logic [2:0] busy;
  // Busy while shifting, so a stall backs up the channel buffer
  assign tx_ready = busy == 3'h0;
  assign tx_shift_idle = busy == 3'h0;
  always_ff @(posedge clk) begin
    got <= 1'b0;
    if (reset) begin
      busy <= 3'h0;
    end else if (tx_valid && tx_ready) begin
      busy <= slow;
      got <= 1'b1;
      got_byte <= tx_data;
    end else if (busy != 3'h0) begin
      busy <= busy - 3'h1;
    end
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the UART channel register set
`timescale 1ns/1ps
module testbench import uch_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n = 1'b1;
  logic channel_pick = 1'b0;
  uch_req_s req = '0;
  logic rx_valid = 1'b0;
  uch_rx_word_s rx_word = '0;
  logic [3:0] modem_level = 4'h0;
  logic [2:0] slow = 3'h0;
  logic rx_overrun = 1'b0;
  logic rx_timeout = 1'b0;
  logic [3:0] modem_delta = 4'h0;
  logic [7:0] rdata, tx_data, got_byte;
  logic rx_ready, tx_valid, tx_ready, tx_idle, got, irq;
  logic rd_seen = 1'b0;
  logic [15:0] rnd = 16'h0E72;
  logic [4:0] trig [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
  uch_cfg_s cfg;
  logic [7:0] rq [$];
  logic [7:0] tq [$];
  logic [7:0] sent [$];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  uch_regs u_dut (.clk(clk), .reset(reset), .cs_n(cs_n),
    .channel_pick(channel_pick), .req(req), .rdata(rdata),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
    .rx_overrun(rx_overrun), .rx_timeout(rx_timeout), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_shift_idle(tx_idle),
    .modem_level(modem_level), .modem_delta(modem_delta), .cfg(cfg),
    .irq(irq));
  uch_line_model u_line (.clk(clk), .reset(reset), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_shift_idle(tx_idle),
    .slow(slow), .got(got), .got_byte(got_byte));
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One host access; a read notes the value it expects
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    req <= '{addr: a, rd: !w, wr: w, wdata: d};
    if (!w) rq.push_back(d);
    @(posedge clk);
    cs_n <= 1'b1;
    req <= '{addr: a, rd: 1'b0, wr: 1'b0, wdata: ~d};
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_word <= '{brk: 1'b0, frame: 1'b0, parity: 1'b0, data: d};
    sent.push_back(d);
    @(posedge clk);
    while (!rx_ready) @(posedge clk);
    rx_valid <= 1'b0;
    rx_word.data <= ~d;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_seen <= req.rd && !cs_n;
    if (rd_seen) chk("rdata", rq.pop_front(), rdata);
    if (got) chk("tx byte", tq.pop_front(), got_byte);
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    acc(1'b0, ADDR_ISTAT, 8'h01);
    acc(1'b1, ADDR_LSTAT, 8'hFF);
    acc(1'b1, ADDR_MSTAT, 8'hFF);
    acc(1'b0, ADDR_LSTAT, LSTAT_RESET);
    modem_level <= rnd[3:0];
    acc(1'b0, ADDR_MSTAT, {rnd[3:0], 4'h0});
    for (int i = 0; i < 4; i++) begin
      rnd = lf(rnd);
      acc(1'b1, ADDR_SCRATCH, rnd[7:0]);
      acc(1'b0, ADDR_SCRATCH, rnd[7:0]);
      acc(1'b1, ADDR_LCTL, {1'b0, rnd[14:8]});
      acc(1'b0, ADDR_LCTL, {1'b0, rnd[14:8]});
      acc(1'b1, ADDR_MCTL, {3'h0, rnd[12:8]});
      acc(1'b0, ADDR_MCTL, {3'h0, rnd[12:8]});
    end
    channel_pick <= 1'b1;
    acc(1'b1, ADDR_SCRATCH, ~rnd[7:0]);
    channel_pick <= 1'b0;
    acc(1'b0, ADDR_SCRATCH, rnd[7:0]);
    acc(1'b1, ADDR_LCTL, 8'h83);
    rnd = lf(rnd);
    acc(1'b1, ADDR_DATA, rnd[7:0]);
    acc(1'b1, ADDR_IEN, rnd[15:8]);
    acc(1'b1, ADDR_ISTAT, 8'hFE);
    acc(1'b0, ADDR_DATA, rnd[7:0]);
    acc(1'b0, ADDR_IEN, rnd[15:8]);
    acc(1'b0, ADDR_ISTAT, 8'h06);
    acc(1'b0, ADDR_LCTL, 8'h83);
    acc(1'b1, ADDR_LCTL, 8'h03);
    acc(1'b1, ADDR_IEN, 8'hFF);
    acc(1'b0, ADDR_IEN, 8'h0F);
    acc(1'b1, ADDR_IEN, 8'h01);
    acc(1'b1, ADDR_ISTAT, 8'h07);
    for (int i = 0; i < 6; i++) begin
      rnd = lf(rnd);
      slow <= rnd[10:8];
      tq.push_back(rnd[7:0]);
      acc(1'b1, ADDR_DATA, rnd[7:0]);
    end
    repeat (100) @(posedge clk);
    // Every trigger level: below, at, and back below after one read
    for (int t = 0; t < 4; t++) begin
      acc(1'b1, ADDR_ISTAT, {t[1:0], 6'h01});
      for (int k = 1; k < trig[t]; k++) begin
        rnd = lf(rnd);
        push(rnd[7:0]);
      end
      acc(1'b0, ADDR_ISTAT, 8'hC1);
      rnd = lf(rnd);
      push(rnd[7:0]);
      acc(1'b0, ADDR_ISTAT, 8'hC4);
      chk("irq", 8'h01, {7'h00, irq});
      acc(1'b0, ADDR_LSTAT, 8'h61);
      acc(1'b0, ADDR_DATA, sent.pop_front());
      @(posedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      acc(1'b0, ADDR_ISTAT, 8'hC1);
      while (sent.size() > 0) acc(1'b0, ADDR_DATA, sent.pop_front());
      acc(1'b0, ADDR_LSTAT, 8'h60);
    end
    acc(1'b1, ADDR_ISTAT, 8'hC0);
    acc(1'b0, ADDR_ISTAT, 8'h01);
    push(8'hA5);
    acc(1'b0, ADDR_ISTAT, 8'h04);
    acc(1'b0, ADDR_DATA, sent.pop_front());
    // All sources pending at once, then cleared in priority order
    acc(1'b1, ADDR_ISTAT, 8'h01);
    acc(1'b1, ADDR_IEN, 8'h0F);
    rx_overrun <= 1'b1;
    modem_delta <= 4'h5;
    rx_timeout <= 1'b1;
    @(posedge clk);
    rx_overrun <= 1'b0;
    modem_delta <= 4'h0;
    rnd = lf(rnd);
    push(rnd[7:0]);
    acc(1'b0, ADDR_ISTAT, 8'hC6);
    acc(1'b0, ADDR_LSTAT, 8'h63);
    acc(1'b0, ADDR_ISTAT, 8'hCC);
    rx_timeout <= 1'b0;
    acc(1'b0, ADDR_ISTAT, 8'hC4);
    acc(1'b0, ADDR_DATA, sent.pop_front());
    acc(1'b0, ADDR_ISTAT, 8'hC2);
    acc(1'b0, ADDR_ISTAT, 8'hC0);
    acc(1'b0, ADDR_MSTAT, {modem_level, 4'h5});
    acc(1'b0, ADDR_ISTAT, 8'hC1);
    // Concurrent write reaches this channel under the other select
    acc(1'b1, ADDR_LCTL, 8'h83);
    acc(1'b1, ADDR_ISTAT, 8'h01);
    acc(1'b1, ADDR_LCTL, 8'h03);
    rnd = lf(rnd);
    channel_pick <= 1'b1;
    acc(1'b1, ADDR_SCRATCH, rnd[7:0]);
    channel_pick <= 1'b0;
    acc(1'b0, ADDR_SCRATCH, rnd[7:0]);
    repeat (3) @(posedge clk);
    chk("tx queue", 8'h00, 8'(tq.size()));
    stop_test();
  end
endmodule
